// >>> core/msg_vec_pkg.sv
// Package for interprocessor message and vector interrupt block
package msg_vec_pkg;
  localparam int          NUM_MSG        = 8;
  localparam int          ADDR_W         = 24;
  localparam int          REG_W          = 32;
  localparam int          SEL_W          = 4;
  // Register selects on the io_processor register port
  localparam logic [3:0]  SEL_MSG_BASE   = 4'h0;
  localparam logic [3:0]  SEL_VECTOR     = 4'h8;
  localparam logic [3:0]  SEL_STATUS     = 4'h9;
  // Field positions in system_status_word
  localparam int          DWP_BIT        = 12;
  localparam int          VIP_BIT        = 13;
  localparam logic [31:0] DWP_MASK       = 32'h0000_1000;
  // Entry address of the vector interrupt in the vector table (plain default)
  localparam logic [31:0] VECTOR_RESET   = 32'h0002_0040;
  // Latency: six cycles, five of them no-operation
  localparam int          CLK_NS         = 100;
  localparam int          LATENCY_CYC    = 6;
  localparam int          NOP_CYC        = 5;
  localparam logic [2:0]  NOP_LAST       = 3'(NOP_CYC - 1);
  // Longest direct write delay, in cycles
  localparam int          DW_MAX_CYC     = 12;
  localparam logic [3:0]  DW_LIMIT       = 4'(DW_MAX_CYC - 1);

  typedef enum logic [1:0] {ST_IDLE, ST_PENDING, ST_NOP, ST_SERVICE} vec_state_t;

  typedef struct packed {
    logic                   wr;
    logic                   rd;
    logic                   from_core;
    logic [SEL_W-1:0]       sel;
    logic [REG_W-1:0]       wdata;
  } reg_req_t;

  typedef struct packed {
    logic                   push_status;
    logic                   pop_status;
    logic                   branch;
    logic [ADDR_W-1:0]      target;
  } seq_ctl_t;
endpackage

// >>> core/interproc_message_vector_irq.sv
// Interprocessor message registers, vector interrupt and direct write pending logic
`timescale 1ns/100ps
module interproc_message_vector_irq (
  input  wire logic                    clk_in,
  input  wire logic                    nrst_in,
  input  wire msg_vec_pkg::reg_req_t   req_in,
  input  wire logic                    dw_start_in,
  input  wire logic                    dw_grant_in,
  input  wire logic                    ret_from_irq_in,
  input  wire logic                    bus_lock_bit_in,
  input  wire logic                    bus_master_condition_in,
  input  wire logic                    sem_read_in,
  output logic [31:0]                  rdata_out,
  output logic                         rvalid_out,
  output logic                         irq_out,
  output msg_vec_pkg::seq_ctl_t        seq_out,
  output logic                         vector_pending_flag_out,
  output logic                         direct_write_pending_flag_out,
  output logic                         sem_read_go_out
);
  import msg_vec_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [REG_W-1:0] message_registers [NUM_MSG];
  logic [REG_W-1:0] next_message_registers [NUM_MSG];
  logic [REG_W-1:0] vector_interrupt_address;
  logic [REG_W-1:0] next_vector_interrupt_address;
  vec_state_t       state;
  vec_state_t       next_state;
  logic [2:0]       nop_cnt;
  logic [2:0]       next_nop_cnt;
  logic             vip;
  logic             next_vip;
  logic             dwp;
  logic             next_dwp;
  logic [3:0]       dw_cnt;
  logic [3:0]       next_dw_cnt;
  logic [31:0]      next_rdata;
  logic             next_rvalid;
  logic             next_irq;
  seq_ctl_t         next_seq;
  logic             next_sem_go;
  logic             vec_wr;
  logic [31:0]      status_word;

  // Core writes never retrigger; only external masters may
  assign vec_wr = req_in.wr && !req_in.from_core && req_in.sel == SEL_VECTOR;
  always_comb begin
    status_word = '0;
    status_word[DWP_BIT] = dwp;
    status_word[VIP_BIT] = vip;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Message registers and read port
  always_comb begin
    for (int i = 0; i < NUM_MSG; i++) begin
      next_message_registers[i] = message_registers[i];
      if (req_in.wr && req_in.sel == SEL_MSG_BASE + 4'(i)) begin
        next_message_registers[i] = req_in.wdata;
      end
    end
    next_rvalid = req_in.rd;
    next_rdata  = '0;
    if (req_in.rd) begin
      if (req_in.sel < SEL_VECTOR) begin
        next_rdata = message_registers[req_in.sel[2:0]];
      end else if (req_in.sel == SEL_VECTOR) begin
        next_rdata = vector_interrupt_address;
      end else if (req_in.sel == SEL_STATUS) begin
        next_rdata = status_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Vector interrupt sequencing
  always_comb begin
    next_state = state;
    next_vector_interrupt_address = vector_interrupt_address;
    next_vip = vip;
    next_nop_cnt = nop_cnt;
    next_irq = 1'b0;
    next_seq = '0;
    next_seq.target = vector_interrupt_address[ADDR_W-1:0];
    // Routine itself may write the token back from the core side
    if (req_in.wr && req_in.from_core && req_in.sel == SEL_VECTOR
        && state == ST_SERVICE) begin
      next_vector_interrupt_address = req_in.wdata;
    end
    case (state)
      ST_IDLE: begin
        if (vec_wr) begin
          next_vector_interrupt_address = req_in.wdata;
          next_vip   = 1'b1;
          next_irq   = 1'b1;
          next_state = ST_PENDING;
        end
      end
      ST_PENDING: begin
        next_irq = 1'b1;
        next_seq.push_status = 1'b1;
        next_nop_cnt = '0;
        next_state = ST_NOP;
        if (vec_wr) begin
          next_vector_interrupt_address = req_in.wdata;
          next_seq.target = req_in.wdata[ADDR_W-1:0];
        end
      end
      ST_NOP: begin
        // Address frozen once the push is issued
        if (nop_cnt == NOP_LAST) begin
          next_seq.branch = 1'b1;
          next_state = ST_SERVICE;
        end else begin
          next_nop_cnt = nop_cnt + 3'h1;
        end
      end
      ST_SERVICE: begin
        // New vectors are dropped here
        if (ret_from_irq_in) begin
          next_seq.pop_status = 1'b1;
          next_vip   = 1'b0;
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Direct write pending; register writes are not ordered behind it
  always_comb begin
    next_dwp = dwp;
    next_dw_cnt = dw_cnt;
    if (dwp) begin
      if (dw_grant_in || dw_cnt == DW_LIMIT) begin
        next_dwp = 1'b0;
      end else begin
        next_dw_cnt = dw_cnt + 4'h1;
      end
    end
    if (dw_start_in) begin
      next_dwp = 1'b1;
      next_dw_cnt = '0;
    end
    next_sem_go = sem_read_in && (!bus_lock_bit_in || bus_master_condition_in);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < NUM_MSG; i++) begin
        message_registers[i] <= '0;
      end
      vector_interrupt_address <= VECTOR_RESET;
      state <= ST_IDLE;
      nop_cnt <= '0;
      vip <= 1'b0;
      dwp <= 1'b0;
      dw_cnt <= '0;
      rdata_out <= '0;
      rvalid_out <= 1'b0;
      irq_out <= 1'b0;
      seq_out <= '0;
      vector_pending_flag_out <= 1'b0;
      direct_write_pending_flag_out <= 1'b0;
      sem_read_go_out <= 1'b0;
    end else begin
      message_registers <= next_message_registers;
      vector_interrupt_address <= next_vector_interrupt_address;
      state <= next_state;
      nop_cnt <= next_nop_cnt;
      vip <= next_vip;
      dwp <= next_dwp;
      dw_cnt <= next_dw_cnt;
      rdata_out <= next_rdata;
      rvalid_out <= next_rvalid;
      irq_out <= next_irq;
      seq_out <= next_seq;
      vector_pending_flag_out <= next_vip;
      direct_write_pending_flag_out <= next_dwp;
      sem_read_go_out <= next_sem_go;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_vec_irq_raise: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state == ST_IDLE && vec_wr) |=> irq_out && vip)
    else $error("vector write did not raise interrupt");
  a_vec_latency: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $rose(seq_out.push_status) |-> ##(NOP_CYC) seq_out.branch)
    else $error("branch not five cycles after push");
  a_vec_no_early: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $rose(seq_out.push_status) |=> !seq_out.branch [*4])
    else $error("branch too early");
  a_vec_ignore_core: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state == ST_IDLE && req_in.wr && req_in.from_core) |=> state == ST_IDLE)
    else $error("core write triggered vector");
  a_vec_service_ign: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state == ST_SERVICE && vec_wr && !ret_from_irq_in) |=> state == ST_SERVICE
      && $stable(vector_interrupt_address))
    else $error("write during service not ignored");
  a_vec_pop_clear: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state == ST_SERVICE && ret_from_irq_in) |=> seq_out.pop_status && !vip)
    else $error("return did not pop and clear");
  a_vec_replace: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state == ST_PENDING && vec_wr) |=> vector_interrupt_address == $past(req_in.wdata))
    else $error("pending vector not replaced");
  a_dwp_bound: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ($rose(dwp) && !dw_start_in) |-> ##[1:12] (!dwp || dw_start_in))
    else $error("direct write pending too long");
  // Checked on the read path, so a wrong mux leg is caught too
  a_dwp_status_bit: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (req_in.rd && req_in.sel == SEL_STATUS) |=> ((rdata_out & DWP_MASK) != '0) == $past(dwp))
    else $error("status bit misplaced");
  a_sem_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (sem_read_in && bus_lock_bit_in && !bus_master_condition_in) |=> !sem_read_go_out)
    else $error("semaphore read not held off");
  a_msg_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !(req_in.wr && req_in.sel == SEL_MSG_BASE) |=> $stable(message_registers[0]))
    else $error("message register changed");
endmodule

// >>> sim/msg_master_model.sv
// Bus master model driving the register port and direct writes
`timescale 1ns/100ps
module msg_master_model (
  input  wire logic            clk_in,
  input  wire logic            dwp_in,
  output msg_vec_pkg::reg_req_t req_out,
  output logic                 dw_start_out,
  output logic                 dw_grant_out
);
  import msg_vec_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    req_out = '0;
    dw_start_out = 1'b0;
    dw_grant_out = 1'b0;
  end

  // Held until the taking edge; caller must end a burst with idle
  task automatic access(input logic w, input logic core, input logic [3:0] s,
                        input logic [31:0] d);
    // Sole requester; no host traffic competes for these registers
    req_out <= '{wr: w, rd: !w, from_core: core, sel: s, wdata: d};
    @(posedge clk_in);
    #1;
  endtask

  // Released bus drops the strobes and shows inverted select and data lines, not the last value
  task automatic idle();
    req_out <= {3'b000, ~req_out.sel, ~req_out.wdata};
    @(posedge clk_in);
    #1;
  endtask

  // Holds the vector write while a direct write is outstanding, for at most 20 cycles
  task automatic vector_write(input logic [31:0] d);
    int n;
    n = 0;
    while (dwp_in !== 1'b0 && n < 20) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    access(1'b1, 1'b0, SEL_VECTOR, d);
  endtask

  // Lag 0 models a landing held off by chained transfers
  task automatic direct_write(input int lag);
    dw_start_out <= 1'b1;
    @(posedge clk_in);
    #1;
    dw_start_out <= 1'b0;
    if (lag > 0) begin
      repeat (lag) @(posedge clk_in);
      #1;
      dw_grant_out <= 1'b1;
      @(posedge clk_in);
      #1;
      dw_grant_out <= 1'b0;
    end
  endtask
endmodule

// >>> sim/interproc_message_vector_irq_bench.sv
// Testbench for the message and vector interrupt block
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module interproc_message_vector_irq_bench;
  import msg_vec_pkg::*;
  logic        clk_in, nrst_in, ret_in, lock_in, master_in, sem_in;
  logic        dws, dwg, rvalid, irq, vpf, dwpf, go;
  reg_req_t    req;
  seq_ctl_t    seq;
  logic [31:0] rdata, d;
  int          checks, error_cnt, cyc, n, i;
  ////////////////////////////////////////////////////////////////////////////
  msg_master_model msg_master_model_inst (.clk_in(clk_in), .dwp_in(dwpf),
    .req_out(req), .dw_start_out(dws), .dw_grant_out(dwg));
  interproc_message_vector_irq interproc_message_vector_irq_inst (
    .clk_in(clk_in), .nrst_in(nrst_in), .req_in(req), .dw_start_in(dws),
    .dw_grant_in(dwg), .ret_from_irq_in(ret_in), .bus_lock_bit_in(lock_in),
    .bus_master_condition_in(master_in), .sem_read_in(sem_in),
    .rdata_out(rdata), .rvalid_out(rvalid), .irq_out(irq), .seq_out(seq),
    .vector_pending_flag_out(vpf), .direct_write_pending_flag_out(dwpf),
    .sem_read_go_out(go));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  // Generous ceiling; the sequence needs well under 200 cycles
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic tick(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask

  task automatic rd(input logic [3:0] s, output logic [31:0] q);
    int k;
    k = 0;
    msg_master_model_inst.access(1'b0, 1'b0, s, 32'h0);
    while (rvalid !== 1'b1 && k < 4) begin
      tick(1);
      k++;
    end
    `CHK("rvalid", 1'b1, rvalid)
    q = rdata;
    msg_master_model_inst.idle();
  endtask

  task automatic tally_and_finish();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {nrst_in, ret_in, lock_in, master_in, sem_in} = 5'h00;
    {checks, error_cnt, cyc} = '0;
    tick(4);
    nrst_in = 1'b1;
    rd(SEL_VECTOR, d);
    `CHK("vector reset", VECTOR_RESET, d)
    for (i = 0; i < NUM_MSG; i++) begin
      msg_master_model_inst.access(1'b1, 1'b0, 4'(i), 32'(i + 1) * 32'h0101_0101);
    end
    msg_master_model_inst.idle();
    for (i = 0; i < 2 * NUM_MSG; i++) begin
      rd(4'(i % NUM_MSG), d);
      `CHK("message", 32'(i % NUM_MSG + 1) * 32'h0101_0101, d)
    end
    msg_master_model_inst.access(1'b1, 1'b1, SEL_VECTOR, 32'h0000_0100);
    msg_master_model_inst.idle();
    `CHK("core irq", 1'b0, irq)
    rd(SEL_VECTOR, d);
    `CHK("core write", VECTOR_RESET, d)
    // Second write lands while still pending, before the branch
    msg_master_model_inst.vector_write(32'hab00_1234);
    `CHK("irq", 1'b1, irq)
    `CHK("pending", 1'b1, vpf)
    msg_master_model_inst.vector_write(32'hcd00_5678);
    `CHK("push", 1'b1, seq.push_status)
    msg_master_model_inst.idle();
    n = 3;
    while (seq.branch !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    `CHK("latency", 1 + LATENCY_CYC, n)
    `CHK("target", 24'h00_5678, seq.target)
    msg_master_model_inst.vector_write(32'h0000_0200);
    msg_master_model_inst.idle();
    `CHK("ignored irq", 1'b0, irq)
    rd(SEL_VECTOR, d);
    `CHK("vector kept", 32'hcd00_5678, d)
    rd(SEL_STATUS, d);
    `CHK("status vip", 1'b1, d[VIP_BIT])
    // Routine hands the token back before returning
    msg_master_model_inst.access(1'b1, 1'b1, SEL_VECTOR, 32'h0000_0000);
    msg_master_model_inst.idle();
    rd(SEL_VECTOR, d);
    `CHK("token", 32'h0000_0000, d)
    ret_in = 1'b1;
    tick(1);
    ret_in = 1'b0;
    `CHK("pop", 1'b1, seq.pop_status)
    `CHK("cleared", 1'b0, vpf)
    msg_master_model_inst.direct_write(0);
    `CHK("dw set", 1'b1, dwpf)
    rd(SEL_STATUS, d);
    `CHK("dw bit", DWP_MASK, d & DWP_MASK)
    n = 3;
    while (dwpf !== 1'b0 && n < 30) begin
      tick(1);
      n++;
    end
    `CHK("dw bound", 1'b1, n <= DW_MAX_CYC + 1)
    msg_master_model_inst.direct_write(3);
    `CHK("dw grant", 1'b0, dwpf)
    sem_in = 1'b1;
    lock_in = 1'b1;
    tick(3);
    `CHK("sem held", 1'b0, go)
    master_in = 1'b1;
    tick(2);
    `CHK("sem go", 1'b1, go)
    {sem_in, lock_in} = 2'h0;
    tick(2);
    `CHK("sem idle", 1'b0, go)
    // Handshake messaging through data and handshake registers
    msg_master_model_inst.access(1'b1, 1'b0, 4'h2, 32'h0000_00a5);
    msg_master_model_inst.access(1'b1, 1'b0, 4'h3, 32'h0000_0001);
    msg_master_model_inst.idle();
    rd(4'h3, d);
    `CHK("handshake set", 32'h0000_0001, d)
    rd(4'h2, d);
    `CHK("handshake data", 32'h0000_00a5, d)
    msg_master_model_inst.access(1'b1, 1'b1, 4'h3, 32'h0000_0000);
    msg_master_model_inst.idle();
    rd(4'h3, d);
    `CHK("handshake done", 32'h0000_0000, d)
    // Write-back messaging; zero marks an empty slot
    msg_master_model_inst.access(1'b1, 1'b0, 4'h4, 32'h0000_5a5a);
    msg_master_model_inst.idle();
    rd(4'h4, d);
    `CHK("writeback data", 32'h0000_5a5a, d)
    msg_master_model_inst.access(1'b1, 1'b1, 4'h4, 32'h0000_0000);
    msg_master_model_inst.idle();
    rd(4'h4, d);
    `CHK("writeback clear", 32'h0000_0000, d)
    // Poll for the token, fill a message, then interrupt after a direct write
    n = 0;
    d = 32'hffff_ffff;
    while (d !== 32'h0000_0000 && n < 8) begin
      rd(SEL_VECTOR, d);
      n++;
    end
    `CHK("token poll", 32'h0000_0000, d)
    msg_master_model_inst.access(1'b1, 1'b0, 4'h5, 32'h0000_0077);
    msg_master_model_inst.idle();
    msg_master_model_inst.direct_write(0);
    msg_master_model_inst.vector_write(32'h0000_0300);
    `CHK("dw before vector", 1'b0, dwpf)
    `CHK("message irq", 1'b1, irq)
    msg_master_model_inst.idle();
    rd(4'h5, d);
    `CHK("message kept", 32'h0000_0077, d)
    tally_and_finish();
  end
endmodule
